//--- rtl/crs_pkg.sv
// Package: constants and carriers for the core reset sequencer
package crs_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int HOLD_1MS_US = 1000;
	localparam int SEMI_95MS_US = 95000;
	localparam int WDR_2MS_US = 2000;
	localparam int HOLD_CYC = HOLD_1MS_US * (CLK_HZ / 1_000_000);
	localparam int SEMI_CYC = SEMI_95MS_US * (CLK_HZ / 1_000_000);
	localparam int WDR_CYC = WDR_2MS_US * (CLK_HZ / 1_000_000);
	localparam int PC_W = 14;
	localparam int SP_W = 8;
	localparam logic [13:0] PC_RESET = 14'h0000;
	localparam logic [13:0] VEC_BASE = 14'h0002;
	localparam logic [13:0] VEC_LAST = 14'h0018;
	localparam logic [13:0] PROG_START = 14'h001a;
	localparam logic [13:0] PROG_END = 14'h1fdf;
	localparam logic [7:0] SP_RESET = 8'h00;
	localparam int NUM_VEC = 12;
	localparam int BIT_POR = 4;
	localparam int BIT_WDR = 6;
	localparam int BIT_BUSRST_EN = 0;
	localparam logic [7:0] PSC_RESET = 8'h00;
	localparam logic [7:0] IO_ZERO = 8'h00;

	typedef enum logic [4:0] {
		ST_POR = 5'h01,
		ST_HOLD = 5'h02,
		ST_SEMI = 5'h04,
		ST_WDR = 5'h08,
		ST_RUN = 5'h10
	} crs_state_e;

	typedef enum logic [2:0] {
		OP_STEP = 3'h0,
		OP_PAGE = 3'h1,
		OP_CALL = 3'h2,
		OP_RET = 3'h3,
		OP_RETURN_FROM_INTERRUPT = 3'h4,
		OP_JUMP = 3'h5,
		OP_NONE = 3'h6
	} crs_op_e;

	typedef struct packed {
		logic rd;
		logic wr;
		logic indexed;
		logic [7:0] addr;
		logic [7:0] data;
	} crs_io_s;

	typedef struct packed {
		logic we;
		logic [7:0] addr;
		logic [7:0] data;
	} crs_mem_s;
endpackage

//--- rtl/crs_core.sv
// Core reset sequencer: reset sources, semi-suspend, PC, stack, I/O address
`timescale 1ns/1ps
module crs_core
	import crs_pkg::*;
#(
	parameter int HOLD_CYCLES = HOLD_CYC,
	parameter int SEMI_CYCLES = SEMI_CYC,
	parameter int WDR_CYCLES = WDR_CYC
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic supply_ok_i,
	input wire logic osc_stable_i,
	input wire logic watchdog_reset_i,
	input wire logic usb_bus_reset_i,
	input wire logic [2:0] op_i,
	input wire logic [PC_W-1:0] target_i,
	input wire logic [1:0] instr_len_i,
	input wire logic carry_i,
	input wire logic zero_i,
	input wire logic irq_i,
	input wire logic [3:0] irq_num_i,
	input wire logic [7:0] stack_rdata_i,
	input wire crs_io_s io_req_i,
	input wire logic [7:0] index_i,
	input wire logic [7:0] acc_i,
	input wire logic [7:0] port_rdata_i,
	input wire logic psc_clr_i,
	input wire logic busrst_irq_en_i,
	input wire logic global_irq_en_i,
	output logic cpu_run_o,
	output logic irq_block_o,
	output logic periph_reset_o,
	output logic [PC_W-1:0] pc_o,
	output logic in_program_o,
	output logic carry_o,
	output logic zero_o,
	output crs_mem_s stack_o,
	output logic [SP_W-1:0] program_stack_pointer_o,
	output logic [7:0] stack_raddr_o,
	output crs_io_s io_port_o,
	output logic [7:0] acc_o,
	output logic acc_load_o,
	output logic [7:0] psc_o,
	output logic busrst_pending_o,
	output logic busrst_take_o
);
	// ref_clk_i is the crystal-derived core clock
	localparam int CW = 32;

	crs_state_e state, next_state;
	logic [CW-1:0] cnt, next_cnt;
	logic [PC_W-1:0] pc, next_pc;
	logic [SP_W-1:0] sp, next_sp;
	logic carry, next_carry, zero, next_zero;
	logic [1:0] pop_ph, next_pop_ph;
	logic [7:0] pop_lo, next_pop_lo;
	logic pop_return_from_interrupt, next_pop_return_from_interrupt;
	logic [7:0] psc, next_psc;
	logic pend, next_pend;
	crs_mem_s stk, next_stk;
	logic push_hi, next_push_hi;
	logic [7:0] hi_byte, next_hi_byte;
	crs_io_s iop, next_iop;
	logic [7:0] acc, next_acc;
	logic accl, next_accl;
	logic [PC_W-1:0] ret_pc;
	logic running;

	// Sequencer
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		case (state)
			ST_POR: begin
				next_cnt = '0;
				if (supply_ok_i && osc_stable_i)
					next_state = ST_HOLD;
			end
			ST_HOLD: begin
				next_cnt = cnt + 32'd1;
				if (cnt >= CW'(HOLD_CYCLES - 1)) begin
					next_state = ST_SEMI;
					next_cnt = '0;
				end
			end
			ST_SEMI: begin
				next_cnt = cnt + 32'd1;
				if (usb_bus_reset_i)
					next_state = ST_RUN;
				else if (cnt >= CW'(SEMI_CYCLES - 1))
					next_state = ST_RUN;
			end
			ST_WDR: begin
				next_cnt = cnt + 32'd1;
				if (cnt >= CW'(WDR_CYCLES - 1))
					next_state = ST_RUN;
			end
			ST_RUN: next_cnt = '0;
			default: next_state = ST_POR;
		endcase
		if (!supply_ok_i)
			next_state = ST_POR;
		else if (watchdog_reset_i && state != ST_POR) begin
			next_state = ST_WDR;
			next_cnt = '0;
		end
	end

	assign running = (state == ST_RUN);
	assign ret_pc = pc + PC_W'(instr_len_i);

	// Program counter, flags, stack
	always_comb begin
		next_pc = pc;
		next_sp = sp;
		next_carry = carry;
		next_zero = zero;
		next_pop_ph = pop_ph;
		next_pop_lo = pop_lo;
		next_pop_return_from_interrupt = pop_return_from_interrupt;
		next_stk = '0;
		next_push_hi = 1'b0;
		next_hi_byte = hi_byte;
		if (!running) begin
			next_pc = PC_RESET;
			next_sp = SP_RESET;
			next_carry = 1'b0;
			next_zero = 1'b0;
			next_pop_ph = 2'd0;
		end else if (push_hi) begin
			next_stk = '{we: 1'b1, addr: sp, data: hi_byte};
			next_sp = sp + 8'd1;
		end else if (pop_ph == 2'd1) begin
			next_pop_lo = stack_rdata_i;
			next_sp = sp - 8'd1;
			next_pop_ph = 2'd2;
		end else if (pop_ph == 2'd2) begin
			// Upper frame byte came off first and sits in pop_lo
			next_pc = {pop_lo[5:0], stack_rdata_i};
			if (pop_return_from_interrupt) begin
				next_carry = pop_lo[7];
				next_zero = pop_lo[6];
			end
			next_pop_ph = 2'd0;
		end else if (irq_i && irq_num_i < 4'(NUM_VEC)) begin
			next_stk = '{we: 1'b1, addr: sp, data: pc[7:0]};
			next_hi_byte = {carry, zero, pc[13:8]};
			next_push_hi = 1'b1;
			next_sp = sp + 8'd1;
			next_pc = VEC_BASE + {9'h000, irq_num_i, 1'b0};
		end else begin
			case (op_i)
				OP_STEP: begin
					next_pc = {pc[13:8], pc[7:0] + {6'h00, instr_len_i}};
					next_carry = carry_i;
					next_zero = zero_i;
				end
				OP_PAGE: next_pc = {pc[13:8] + 6'h01, 8'h00};
				OP_JUMP: next_pc = target_i;
				OP_CALL: begin
					next_stk = '{we: 1'b1, addr: sp, data: ret_pc[7:0]};
					next_hi_byte = {carry, zero, ret_pc[13:8]};
					next_push_hi = 1'b1;
					next_sp = sp + 8'd1;
					next_pc = target_i;
				end
				OP_RET, OP_RETURN_FROM_INTERRUPT: begin
					next_sp = sp - 8'd1;
					next_pop_ph = 2'd1;
					next_pop_return_from_interrupt = (op_i == OP_RETURN_FROM_INTERRUPT);
				end
				default: next_pc = pc;
			endcase
		end
	end

	// Stack read address is the stack pointer, whatever the pop phase
	assign stack_raddr_o = sp;

	// I/O access, status and bus-reset pending
	always_comb begin
		next_iop = '0;
		next_acc = acc;
		next_accl = 1'b0;
		next_psc = psc;
		next_pend = pend;
		if (running && io_req_i.wr) begin
			next_iop = io_req_i;
			next_iop.data = acc_i;
			if (io_req_i.indexed)
				next_iop.addr = index_i + io_req_i.addr;
		end
		if (running && io_req_i.rd) begin
			next_iop = io_req_i;
			next_acc = port_rdata_i;
			next_accl = 1'b1;
		end
		if (psc_clr_i)
			next_psc = PSC_RESET;
		if (state == ST_POR)
			next_psc = PSC_RESET | (8'h01 << BIT_POR);
		if (watchdog_reset_i && state != ST_POR)
			next_psc = PSC_RESET | (8'h01 << BIT_WDR);
		if (state == ST_SEMI && usb_bus_reset_i)
			next_pend = 1'b1;
		else if (busrst_take_o)
			next_pend = 1'b0;
		if (state == ST_POR || state == ST_WDR)
			next_pend = 1'b0;
	end

	assign busrst_take_o = running && pend && busrst_irq_en_i
		&& global_irq_en_i;

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= ST_POR;
			cnt <= '0;
			pc <= PC_RESET;
			sp <= SP_RESET;
			carry <= 1'b0;
			zero <= 1'b0;
			pop_ph <= 2'd0;
			pop_lo <= 8'h00;
			pop_return_from_interrupt <= 1'b0;
			stk <= '0;
			push_hi <= 1'b0;
			hi_byte <= 8'h00;
			iop <= '0;
			acc <= IO_ZERO;
			accl <= 1'b0;
			psc <= PSC_RESET | (8'h01 << BIT_POR);
			pend <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			pc <= next_pc;
			sp <= next_sp;
			carry <= next_carry;
			zero <= next_zero;
			pop_ph <= next_pop_ph;
			pop_lo <= next_pop_lo;
			pop_return_from_interrupt <= next_pop_return_from_interrupt;
			stk <= next_stk;
			push_hi <= next_push_hi;
			hi_byte <= next_hi_byte;
			iop <= next_iop;
			acc <= next_acc;
			accl <= next_accl;
			psc <= next_psc;
			pend <= next_pend;
		end
	end

	assign cpu_run_o = running;
	assign irq_block_o = (state != ST_SEMI) && !running;
	assign periph_reset_o = (state == ST_POR) || (state == ST_WDR);
	assign pc_o = pc;
	assign in_program_o = (pc >= PROG_START) && (pc <= PROG_END);
	assign carry_o = carry;
	assign zero_o = zero;
	assign stack_o = stk;
	assign program_stack_pointer_o = sp;
	assign io_port_o = iop;
	assign acc_o = acc;
	assign acc_load_o = accl;
	assign psc_o = psc;
	assign busrst_pending_o = pend;

	chk_pc_reset_zero: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i) !running |=> pc == PC_RESET)
		else $error("pc not cleared while held");

	sequence s_frame_pair;
		stk.we ##1 stk.we;
	endsequence

	chk_hold_len: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		state == ST_HOLD && cnt < CW'(HOLD_CYCLES - 1) && supply_ok_i
		&& !watchdog_reset_i |=> state == ST_HOLD)
		else $error("hold phase too short");

	chk_bus_abort: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		state == ST_SEMI && usb_bus_reset_i && supply_ok_i
		&& !watchdog_reset_i |=> running && pend)
		else $error("bus reset did not abort semi-suspend");

	chk_wdr_flag: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		watchdog_reset_i && state != ST_POR |=> psc[BIT_WDR])
		else $error("watchdog cause not recorded");

	chk_por_flag: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i) state == ST_POR |=> psc[BIT_POR])
		else $error("power-on cause not recorded");

	chk_page_wrap: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		running && !push_hi && pop_ph == 2'd0 && !irq_i
		&& op_i == OP_STEP && supply_ok_i && !watchdog_reset_i
		|=> pc[13:8] == $past(pc[13:8]))
		else $error("step changed upper pc bits");

	chk_push_pair: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i) push_hi && running |-> s_frame_pair)
		else $error("stack frame not two bytes");

	chk_ret_flags: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		running && pop_ph == 2'd2 && !pop_return_from_interrupt && supply_ok_i
		&& !watchdog_reset_i |=> carry == $past(carry))
		else $error("plain return altered carry");

	chk_idx_addr: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		running && io_req_i.wr && !io_req_i.rd && io_req_i.indexed
		|=> iop.addr == $past(index_i) + $past(io_req_i.addr))
		else $error("indexed address wrong");

	chk_sp_reset: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i) state == ST_WDR |=> sp == SP_RESET)
		else $error("stack pointer not cleared");
endmodule

//--- test/crs_supply_model.sv
// Supply monitor and upstream bus model for the reset sequencer
`timescale 1ns/1ps
module crs_supply_model (
	input wire logic ref_clk_i,
	input wire logic power_i,
	input wire logic [3:0] ramp_i,
	input wire logic bus_rst_i,
	output logic supply_ok_o,
	output logic osc_stable_o,
	output logic usb_bus_reset_o
);
	logic [3:0] cnt;
	initial begin
		cnt = 4'h0;
		supply_ok_o = 1'b0;
		osc_stable_o = 1'b0;
		usb_bus_reset_o = 1'b0;
	end
	// Oscillator settles one cycle after supply, never before it
	always @(posedge ref_clk_i) begin
		cnt <= power_i ? ((cnt == 4'hf) ? cnt : cnt + 4'h1) : 4'h0;
		supply_ok_o <= power_i && (cnt >= ramp_i);
		osc_stable_o <= supply_ok_o && power_i;
		usb_bus_reset_o <= bus_rst_i && power_i;
	end
endmodule

//--- test/tb_core_reset_sequencer.sv
// Self-checking bench for the core reset sequencer
`timescale 1ns/1ps
`define CK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_core_reset_sequencer import crs_pkg::*; ();
	localparam int H = 4;
	localparam int S = 8;
	localparam int W = 6;
	logic clk = 1'b0, rstn = 1'b0, pwr = 1'b0, brq = 1'b0, wdt = 1'b0;
	logic irq = 1'b0, c = 1'b0, z = 1'b0, pclr = 1'b0, ben = 1'b0;
	logic gie = 1'b0;
	logic [3:0] inum = 4'h0, ramp = 4'h5;
	logic [2:0] op = OP_NONE;
	logic [13:0] tgt = 14'h0000;
	logic [1:0] len = 2'h1;
	logic [7:0] idx = 8'h00, acc = 8'h00, prd = 8'h00;
	crs_io_s req = '0;
	logic sok, ost, ubr, run, iblk, prst, inprog, co, zo, accld, bpend, btake;
	logic [13:0] pc;
	logic [7:0] sp, sra, srd, acco, psc;
	crs_mem_s stk;
	crs_io_s iop;
	logic [7:0] mem [0:255];
	int mismatches = 0, checks = 0, pushes = 0, open_cyc = 0;
	always #50 clk = ~clk;
	// Stack SRAM beside the core, read back combinationally
	always @(posedge clk) begin
		if (stk.we === 1'b1) begin
			mem[stk.addr] <= stk.data;
			pushes++;
		end
	end
	assign srd = mem[sra];
	crs_supply_model u_crs_supply_model (.ref_clk_i(clk), .power_i(pwr),
		.ramp_i(ramp), .bus_rst_i(brq), .supply_ok_o(sok),
		.osc_stable_o(ost), .usb_bus_reset_o(ubr));
	crs_core #(.HOLD_CYCLES(H), .SEMI_CYCLES(S), .WDR_CYCLES(W)) u_crs_core (
		.ref_clk_i(clk), .resetn_i(rstn), .supply_ok_i(sok),
		.osc_stable_i(ost), .watchdog_reset_i(wdt), .usb_bus_reset_i(ubr),
		.op_i(op), .target_i(tgt), .instr_len_i(len), .carry_i(c),
		.zero_i(z), .irq_i(irq), .irq_num_i(inum), .stack_rdata_i(srd),
		.io_req_i(req), .index_i(idx), .acc_i(acc), .port_rdata_i(prd),
		.psc_clr_i(pclr), .busrst_irq_en_i(ben), .global_irq_en_i(gie),
		.cpu_run_o(run), .irq_block_o(iblk), .periph_reset_o(prst),
		.pc_o(pc), .in_program_o(inprog), .carry_o(co), .zero_o(zo),
		.stack_o(stk), .program_stack_pointer_o(sp), .stack_raddr_o(sra),
		.io_port_o(iop), .acc_o(acco), .acc_load_o(accld), .psc_o(psc),
		.busrst_pending_o(bpend), .busrst_take_o(btake));
	task automatic settle(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic do_op(logic [2:0] o, logic [13:0] t, logic [1:0] l,
		logic [1:0] f);
		@(posedge clk);
		op <= o;
		tgt <= t;
		len <= l;
		c <= f[1];
		z <= f[0];
		@(posedge clk);
		op <= OP_NONE;
		settle(3);
	endtask
	task automatic wait_run(output int n);
		n = 0;
		open_cyc = 0;
		while (run !== 1'b1 && n < 200) begin
			open_cyc += (iblk === 1'b0);
			settle(1);
			n++;
		end
	endtask
	task automatic power(logic b, output int n);
		@(posedge clk);
		pwr <= 1'b1;
		brq <= b;
		n = 0;
		settle(1);
		while (!(sok === 1'b1 && ost === 1'b1) && n < 40) begin
			`CK("held", 1'b0, run)
			settle(1);
			n++;
		end
		wait_run(n);
	endtask
	task automatic t_por();
		int n;
		settle(1);
		`CK("psc", 8'h10, psc)
		`CK("pc", PC_RESET, pc)
		`CK("sp", SP_RESET, sp)
		`CK("prst", 1'b1, prst)
		`CK("iblk", 1'b1, iblk)
		`CK("inprog0", 1'b0, inprog)
		power(1'b0, n);
		`CK("semi", 1'b1, n >= H + S && n <= H + S + 2)
		`CK("semi_open", S, open_cyc)
		`CK("prst_run", 1'b0, prst)
		`CK("iblk_run", 1'b0, iblk)
		`CK("pc_run", PC_RESET, pc)
	endtask
	task automatic t_flow();
		int p0;
		do_op(OP_JUMP, 14'h01fe, 2'h1, 2'b00);
		`CK("inprog", 1'b1, inprog)
		do_op(OP_STEP, 14'h0000, 2'h2, 2'b10);
		`CK("wrap", 14'h0100, pc)
		do_op(OP_PAGE, 14'h0000, 2'h1, 2'b10);
		`CK("page", 6'h02, pc[13:8])
		do_op(OP_JUMP, 14'h0123, 2'h1, 2'b10);
		p0 = pushes;
		do_op(OP_CALL, 14'h0456, 2'h2, 2'b10);
		`CK("call", 14'h0456, pc)
		`CK("sp", 8'h02, sp)
		`CK("frame0", 8'h25, mem[0])
		`CK("frame1", 8'h81, mem[1])
		`CK("pushes", 2, pushes - p0)
		do_op(OP_STEP, 14'h0000, 2'h1, 2'b01);
		do_op(OP_RET, 14'h0000, 2'h1, 2'b01);
		`CK("ret", 14'h0125, pc)
		`CK("ret_cz", 2'b01, {co, zo})
		do_op(OP_CALL, 14'h0456, 2'h2, 2'b01);
		do_op(OP_STEP, 14'h0000, 2'h1, 2'b10);
		do_op(OP_RETURN_FROM_INTERRUPT, 14'h0000, 2'h1, 2'b10);
		`CK("return_from_interrupt", 14'h0127, pc)
		`CK("return_from_interrupt_cz", 2'b01, {co, zo})
	endtask
	task automatic t_irq();
		do_op(OP_JUMP, 14'h0300, 2'h1, 2'b01);
		for (int v = 0; v < NUM_VEC; v++) begin
			@(posedge clk);
			irq <= 1'b1;
			inum <= 4'(v);
			@(posedge clk);
			irq <= 1'b0;
			settle(3);
			`CK("vec", VEC_BASE + 14'(2 * v), pc)
			do_op(OP_RETURN_FROM_INTERRUPT, 14'h0000, 2'h1, 2'b01);
			`CK("irq_ret", 14'h0300, pc)
		end
	endtask
	task automatic t_io();
		logic [7:0] xi [4] = '{8'h30, 8'h40, 8'hf0, 8'h30};
		logic [7:0] fa [4] = '{8'h05, 8'h00, 8'h20, 8'h07};
		logic [7:0] ea [4] = '{8'h35, 8'h40, 8'h10, 8'h07};
		int k;
		@(posedge clk);
		req <= '{1'b1, 1'b0, 1'b0, 8'h12, 8'h00};
		prd <= 8'ha5;
		@(posedge clk);
		req <= '0;
		#1;
		`CK("rd_addr", 8'h12, iop.addr)
		k = 0;
		while (accld !== 1'b1 && k < 3) begin
			settle(1);
			k++;
		end
		`CK("acc", 8'ha5, acco)
		// Last entry is a plain write: the index must not leak in
		for (k = 0; k < 4; k++) begin
			@(posedge clk);
			idx <= xi[k];
			acc <= 8'h5c + 8'(k);
			req <= '{1'b0, 1'b1, 1'(k < 3), fa[k], 8'h00};
			@(posedge clk);
			req <= '0;
			#1;
			`CK("io_wr", 1'b1, iop.wr)
			`CK("io_addr", ea[k], iop.addr)
			`CK("io_data", 8'h5c + 8'(k), iop.data)
		end
	endtask
	task automatic t_wdr();
		int n, p0;
		@(posedge clk);
		pclr <= 1'b1;
		@(posedge clk);
		pclr <= 1'b0;
		settle(1);
		`CK("psc_clr", 8'h00, psc)
		p0 = pushes;
		@(posedge clk);
		wdt <= 1'b1;
		@(posedge clk);
		wdt <= 1'b0;
		#1;
		`CK("wdr_run", 1'b0, run)
		`CK("psc_wdr", 8'h40, psc)
		// Core state clears on the first edge spent in watchdog hold
		settle(1);
		`CK("wdr_pc", PC_RESET, pc)
		`CK("wdr_sp", SP_RESET, sp)
		`CK("wdr_z", 1'b0, zo)
		`CK("wdr_prst", 1'b1, prst)
		wait_run(n);
		`CK("wdr_len", 1'b1, n >= W - 2 && n <= W + 1)
		`CK("wdr_blk", 0, open_cyc)
		`CK("wdr_pc0", PC_RESET, pc)
		`CK("no_push", 0, pushes - p0)
	endtask
	task automatic t_brst();
		int n, seen;
		@(posedge clk);
		rstn <= 1'b0;
		pwr <= 1'b0;
		ramp <= 4'h0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		#1;
		`CK("rst_psc", 8'h10, psc)
		`CK("rst_run", 1'b0, run)
		power(1'b1, n);
		`CK("bypass", 1'b1, n >= H && n < H + S)
		`CK("brst_open", 1, open_cyc)
		`CK("brst_pc", PC_RESET, pc)
		`CK("pending", 1'b1, bpend)
		@(posedge clk);
		brq <= 1'b0;
		ben <= 1'b1;
		seen = 0;
		repeat (4) begin
			settle(1);
			seen += (btake === 1'b1);
		end
		`CK("masked", 0, seen)
		`CK("still_pend", 1'b1, bpend)
		@(posedge clk);
		gie <= 1'b1;
		// Take is a one-cycle strobe; look before the next edge
		#1;
		`CK("serviced", 1'b1, btake)
		settle(1);
		`CK("taken", 1'b0, bpend)
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		t_por();
		t_flow();
		t_irq();
		t_io();
		t_wdr();
		t_brst();
		final_report();
	end
	// Whole run needs well under a thousand cycles
	initial begin
		repeat (4000) @(posedge clk);
		mismatches++;
		final_report();
	end
endmodule
